// *** rtl/vsrd_valve_setpoint.v ***
// Valve setpoint ramp, dither, pump floor and tester readings
//
// Strobed register access and the address map were chosen for this implementation.
`timescale 1ns/10ps
`include "vsrd_consts.vh"

module vsrd_valve_setpoint #(
    parameter TENTH_CYCLES = `VSRD_TENTH_CYCLES,
    parameter DITH_HALF_0 = `VSRD_DITH_HALF_0,
    parameter DITH_HALF_1 = `VSRD_DITH_HALF_1,
    parameter DITH_HALF_2 = `VSRD_DITH_HALF_2
) (
    input wire clk,
    input wire rst_n,
    input wire [5:0] addr,
    input wire [31:0] wdata,
    input wire wr_en,
    input wire rd_en,
    output reg [31:0] rdata,
    input wire [9:0] pot_level,
    input wire raise_switch,
    input wire lift_prop_active,
    input wire steer_active,
    input wire key_on,
    input wire [9:0] pump_current,
    input wire [15:0] inv_freq,
    input wire [15:0] enc_freq,
    input wire [15:0] inv_amplitude,
    input wire [15:0] batt_voltage,
    output reg [9:0] proportional_valve,
    output reg [6:0] pump_level,
    output reg [8:0] bus_rate_kbaud,
    output reg [3:0] pump_current_level,
    output reg [6:0] traction_ramp,
    output reg [6:0] pump_ramp
);

    ////////////////////////////////////////////////////////////////////////
    // Pin synchronisers; first stage read only by the second
    reg [9:0] pot_s1, pot_s2;
    reg raise_s1, raise_s2, lift_s1, lift_s2, steer_s1, steer_s2, key_s1, key_s2;
    reg [9:0] pcur_s1, pcur_s2;
    reg [15:0] inv_s1, inv_s2, enc_s1, enc_s2, amp_s1, amp_s2, bat_s1, bat_s2;

    always @(posedge clk) begin
        pot_s1 <= pot_level;
        pot_s2 <= pot_s1;
        raise_s1 <= raise_switch;
        raise_s2 <= raise_s1;
        lift_s1 <= lift_prop_active;
        lift_s2 <= lift_s1;
        steer_s1 <= steer_active;
        steer_s2 <= steer_s1;
        key_s1 <= key_on;
        key_s2 <= key_s1;
        pcur_s1 <= pump_current;
        pcur_s2 <= pcur_s1;
        inv_s1 <= inv_freq;
        inv_s2 <= inv_s1;
        enc_s1 <= enc_freq;
        enc_s2 <= enc_s1;
        amp_s1 <= inv_amplitude;
        amp_s2 <= amp_s1;
        bat_s1 <= batt_voltage;
        bat_s2 <= bat_s1;
    end

    ////////////////////////////////////////////////////////////////////////
    // Settings registers
    reg [9:0] valve_current_floor, valve_current_ceiling;
    reg valve_onoff, valve_on;
    reg [7:0] valve_rise_time, valve_fall_time;
    reg [3:0] dither_level;
    reg [1:0] dither_freq;
    reg [6:0] pump_floor_level, lift_load_boost, steer_pump_boost, steer_pump_trim;
    reg [6:0] traction_ramp_set, pump_ramp_set;
    reg [5:0] traction_min_freq;
    reg [5:0] acc_smooth, inv_smooth, brk_smooth;
    reg [4:0] acc_stop, brk_stop;
    reg [15:0] batt_keyon;
    reg key_d;

    // Writes are range checked; an out-of-range value keeps the old one
    always @(posedge clk) begin
        if (!rst_n) begin
            valve_current_floor <= 10'h000;
            valve_current_ceiling <= `VSRD_PERMILLE_MAX;
            valve_onoff <= 1'b0;
            valve_on <= 1'b0;
            valve_rise_time <= 8'h00;
            valve_fall_time <= 8'h00;
            dither_level <= 4'h0;
            dither_freq <= 2'h0;
            pump_floor_level <= 7'h00;
            lift_load_boost <= 7'h00;
            steer_pump_boost <= 7'h00;
            steer_pump_trim <= 7'h00;
            traction_ramp_set <= 7'h00;
            pump_ramp_set <= 7'h00;
            traction_min_freq <= `VSRD_CREEP_MIN;
            acc_smooth <= `VSRD_SMOOTH_MIN;
            inv_smooth <= `VSRD_SMOOTH_MIN;
            brk_smooth <= `VSRD_SMOOTH_MIN;
            acc_stop <= `VSRD_STOP_MIN;
            brk_stop <= `VSRD_STOP_MIN;
            bus_rate_kbaud <= `VSRD_BAUD_125;
            pump_current_level <= 4'h0;
        end else if (wr_en) begin
            case (addr)
                `VSRD_IDX_VALVE: begin
                    if (wdata[9:0] <= `VSRD_PERMILLE_MAX)
                        valve_current_floor <= wdata[9:0];
                    if (wdata[25:16] <= `VSRD_PERMILLE_MAX)
                        valve_current_ceiling <= wdata[25:16];
                    valve_onoff <= wdata[30];
                    valve_on <= wdata[31];
                end
                `VSRD_IDX_RAMP: begin
                    valve_rise_time <= wdata[7:0];
                    valve_fall_time <= wdata[15:8];
                end
                `VSRD_IDX_DITHER: begin
                    if (wdata[3:0] <= `VSRD_DITH_LEVELS)
                        dither_level <= wdata[3:0];
                    if (wdata[9:8] != 2'h3)
                        dither_freq <= wdata[9:8];
                    if (wdata[24:16] == `VSRD_BAUD_20 || wdata[24:16] == `VSRD_BAUD_50 ||
                        wdata[24:16] == `VSRD_BAUD_125 || wdata[24:16] == `VSRD_BAUD_250 ||
                        wdata[24:16] == `VSRD_BAUD_500)
                        bus_rate_kbaud <= wdata[24:16];
                end
                `VSRD_IDX_PUMP: begin
                    if (wdata[6:0] <= `VSRD_PCT_MAX)
                        pump_floor_level <= wdata[6:0];
                    if (wdata[14:8] <= `VSRD_PCT_MAX)
                        lift_load_boost <= wdata[14:8];
                    if (wdata[22:16] <= `VSRD_PCT_MAX)
                        steer_pump_boost <= wdata[22:16];
                    if (wdata[30:24] <= `VSRD_PCT_MAX)
                        steer_pump_trim <= wdata[30:24];
                end
                `VSRD_IDX_TRACT: begin
                    if (wdata[6:0] <= `VSRD_TENTH_RAMP_MAX)
                        traction_ramp_set <= wdata[6:0];
                    if (wdata[14:8] <= `VSRD_TENTH_RAMP_MAX)
                        pump_ramp_set <= wdata[14:8];
                    if (wdata[21:16] >= `VSRD_CREEP_MIN && wdata[21:16] <= `VSRD_CREEP_MAX)
                        traction_min_freq <= wdata[21:16];
                    if (wdata[27:24] <= `VSRD_IMAX_MAX)
                        pump_current_level <= wdata[27:24];
                end
                `VSRD_IDX_SMOOTH: begin
                    if (wdata[5:0] >= `VSRD_SMOOTH_MIN && wdata[5:0] <= `VSRD_SMOOTH_MAX)
                        acc_smooth <= wdata[5:0];
                    if (wdata[13:8] >= `VSRD_SMOOTH_MIN && wdata[13:8] <= `VSRD_SMOOTH_MAX)
                        inv_smooth <= wdata[13:8];
                    if (wdata[21:16] >= `VSRD_SMOOTH_MIN && wdata[21:16] <= `VSRD_SMOOTH_MAX)
                        brk_smooth <= wdata[21:16];
                end
                `VSRD_IDX_MISC: begin
                    if (wdata[4:0] >= `VSRD_STOP_MIN && wdata[4:0] <= `VSRD_STOP_MAX)
                        acc_stop <= wdata[4:0];
                    if (wdata[12:8] >= `VSRD_STOP_MIN && wdata[12:8] <= `VSRD_STOP_MAX)
                        brk_stop <= wdata[12:8];
                end
                default: begin
                end
            endcase
        end
    end

    // Battery voltage caught on the key-on rising edge
    always @(posedge clk) begin
        if (!rst_n) begin
            key_d <= 1'b0;
            batt_keyon <= 16'h0000;
        end else begin
            key_d <= key_s2;
            if (key_s2 && !key_d)
                batt_keyon <= bat_s2;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Target current from pot position, floor..ceiling linear map
    reg [9:0] target;
    reg [19:0] span_prod;
    always @* begin
        span_prod = 20'h00000;
        if (valve_onoff) begin
            target = valve_on ? valve_current_ceiling : 10'h000;
        end else if (valve_current_ceiling <= valve_current_floor) begin
            target = valve_current_floor;
        end else begin
            // Pot 0 -> floor, pot at full scale -> ceiling
            span_prod = (valve_current_ceiling - valve_current_floor) * pot_s2;
            target = valve_current_floor + span_prod[19:10] +
                     ((pot_s2 == 10'h3ff) ? (valve_current_ceiling - valve_current_floor -
                     span_prod[19:10]) : 10'h000);
        end
    end

    // Ramp: one step per tick so that 0..full scale (1000 permille) spans the set time
    reg [9:0] ramp_val;
    reg [31:0] tick_cnt;
    reg [39:0] step_period;
    reg [7:0] active_time;
    always @* begin
        active_time = (target > ramp_val) ? valve_rise_time : valve_fall_time;
        // Time per permille step = time x 0.1 s / 1000; coarse, rounded down
        step_period = ({32'h0, active_time} * TENTH_CYCLES) / {30'h0, `VSRD_PERMILLE_MAX};
    end

    always @(posedge clk) begin
        if (!rst_n) begin
            ramp_val <= 10'h000;
            tick_cnt <= 32'h00000000;
        end else if (target == ramp_val) begin
            tick_cnt <= 32'h00000000;
        end else if (active_time == 8'h00 || tick_cnt + 32'h1 >= step_period) begin
            tick_cnt <= 32'h00000000;
            if (active_time == 8'h00)
                ramp_val <= target;
            else if (target > ramp_val)
                ramp_val <= ramp_val + 10'h001;
            else
                ramp_val <= ramp_val - 10'h001;
        end else begin
            tick_cnt <= tick_cnt + 32'h1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Dither square wave; trade-off: amplitude steps are linear in level
    reg [31:0] dith_cnt;
    reg dith_phase;
    reg [31:0] dith_half;
    always @* begin
        case (dither_freq)
            2'h1: dith_half = DITH_HALF_1;
            2'h2: dith_half = DITH_HALF_2;
            default: dith_half = DITH_HALF_0;
        endcase
    end

    always @(posedge clk) begin
        if (!rst_n) begin
            dith_cnt <= 32'h00000000;
            dith_phase <= 1'b0;
        end else if (dith_cnt + 32'h1 >= dith_half) begin
            dith_cnt <= 32'h00000000;
            dith_phase <= ~dith_phase;
        end else begin
            dith_cnt <= dith_cnt + 32'h1;
        end
    end

    reg [23:0] dith_amp_full;
    reg [9:0] dith_amp;
    reg [11:0] sum_val;
    reg [9:0] next_valve;
    always @* begin
        // Level n is n/8 of 20.3% of ceiling; 0 disables
        dith_amp_full = dither_level * `VSRD_DITH_STEP * valve_current_ceiling /
                        ({14'h0, `VSRD_PERMILLE_MAX} * {20'h0, `VSRD_DITH_LEVELS});
        dith_amp = dith_amp_full[9:0];
        if (dither_level == 4'h0 || ramp_val == 10'h000)
            sum_val = {2'b00, ramp_val};
        else if (dith_phase)
            sum_val = {2'b00, ramp_val} + {2'b00, dith_amp};
        else
            sum_val = {2'b00, ramp_val} - {2'b00, dith_amp};
        if (sum_val[11])
            next_valve = 10'h000;
        else if (sum_val[10:0] > {1'b0, valve_current_ceiling})
            next_valve = valve_current_ceiling;
        else
            next_valve = sum_val[9:0];
    end

    ////////////////////////////////////////////////////////////////////////
    // Pump level: current-driven boost, raised to at least the floor while raising
    reg [16:0] boost_prod;
    reg [8:0] pump_sum;
    reg [6:0] next_pump;
    always @* begin
        boost_prod = 17'h00000;
        pump_sum = 9'h000;
        if (steer_s2) begin
            boost_prod = pcur_s2 * steer_pump_boost;
            pump_sum = {2'b00, steer_pump_trim} + {2'b00, boost_prod[16:10]};
        end else if (lift_s2) begin
            boost_prod = pcur_s2 * lift_load_boost;
            pump_sum = {2'b00, boost_prod[16:10]};
        end
        if (raise_s2 && pump_sum < {2'b00, pump_floor_level})
            pump_sum = {2'b00, pump_floor_level};
        next_pump = (pump_sum > {2'b00, `VSRD_PCT_MAX}) ? `VSRD_PCT_MAX : pump_sum[6:0];
    end

    // Readings: slip and voltage percent
    reg [15:0] slip;
    reg [6:0] motor_volt_pct;
    reg [22:0] mv_prod;
    always @* begin
        slip = inv_s2 - enc_s2;
        mv_prod = amp_s2 * `VSRD_PCT_MAX / {7'h00, bat_s2};
        if (bat_s2 == 16'h0000 || amp_s2 >= bat_s2)
            motor_volt_pct = `VSRD_PCT_MAX;
        else
            motor_volt_pct = mv_prod[6:0];
    end

    ////////////////////////////////////////////////////////////////////////
    // Registered outputs
    always @(posedge clk) begin
        if (!rst_n) begin
            proportional_valve <= 10'h000;
            pump_level <= 7'h00;
            traction_ramp <= 7'h00;
            pump_ramp <= 7'h00;
        end else begin
            proportional_valve <= next_valve;
            pump_level <= next_pump;
            traction_ramp <= traction_ramp_set;
            pump_ramp <= pump_ramp_set;
        end
    end

    // Read port, data in the cycle after the strobe; unmapped reads zero
    always @(posedge clk) begin
        if (!rst_n) begin
            rdata <= 32'h00000000;
        end else if (rd_en) begin
            case (addr)
                `VSRD_IDX_VALVE: rdata <= {valve_on, valve_onoff, 4'h0, valve_current_ceiling,
                                           6'h00, valve_current_floor};
                `VSRD_IDX_RAMP: rdata <= {16'h0000, valve_fall_time, valve_rise_time};
                `VSRD_IDX_DITHER: rdata <= {7'h00, bus_rate_kbaud, 6'h00, dither_freq,
                                            4'h0, dither_level};
                `VSRD_IDX_PUMP: rdata <= {1'b0, steer_pump_trim, 1'b0, steer_pump_boost,
                                          1'b0, lift_load_boost, 1'b0, pump_floor_level};
                `VSRD_IDX_TRACT: rdata <= {4'h0, pump_current_level, 2'h0, traction_min_freq,
                                           1'b0, pump_ramp_set, 1'b0, traction_ramp_set};
                `VSRD_IDX_SMOOTH: rdata <= {10'h000, brk_smooth, 2'h0, inv_smooth,
                                            2'h0, acc_smooth};
                `VSRD_IDX_MISC: rdata <= {19'h00000, brk_stop, 3'h0, acc_stop};
                `VSRD_IDX_INPUTS: rdata <= {28'h0000000, key_s2, steer_s2, lift_s2, raise_s2};
                `VSRD_IDX_SETPT: rdata <= {6'h00, ramp_val, 6'h00, proportional_valve};
                `VSRD_IDX_PUMPOUT: rdata <= {25'h0000000, pump_level};
                `VSRD_IDX_SLIP: rdata <= {16'h0000, slip};
                `VSRD_IDX_MOTV: rdata <= {25'h0000000, motor_volt_pct};
                `VSRD_IDX_BATT: rdata <= {16'h0000, batt_keyon};
                default: rdata <= 32'h00000000;
            endcase
        end else begin
            rdata <= 32'h00000000;
        end
    end

endmodule

// *** rtl/vsrd_consts.vh ***
// Constants for the valve setpoint, ramp and dither block
`ifndef VSRD_CONSTS_VH
`define VSRD_CONSTS_VH
// Register indices; each register is one 32-bit word, addressed by its index on addr
`define VSRD_IDX_VALVE 6'h00
`define VSRD_IDX_RAMP 6'h01
`define VSRD_IDX_DITHER 6'h02
`define VSRD_IDX_PUMP 6'h03
`define VSRD_IDX_TRACT 6'h04
`define VSRD_IDX_SMOOTH 6'h05
`define VSRD_IDX_MISC 6'h06
`define VSRD_IDX_INPUTS 6'h07
`define VSRD_IDX_SETPT 6'h08
`define VSRD_IDX_PUMPOUT 6'h09
`define VSRD_IDX_SLIP 6'h0a
`define VSRD_IDX_MOTV 6'h0b
`define VSRD_IDX_BATT 6'h0c
// Setting ranges
`define VSRD_PERMILLE_MAX 10'h3e8
`define VSRD_RISE_MAX 8'hff
`define VSRD_TENTH_RAMP_MAX 7'h64
`define VSRD_PCT_MAX 7'h64
`define VSRD_CREEP_MIN 6'h06
`define VSRD_CREEP_MAX 6'h28
`define VSRD_SMOOTH_MIN 6'h0a
`define VSRD_SMOOTH_MAX 6'h32
`define VSRD_STOP_MIN 5'h03
`define VSRD_STOP_MAX 5'h14
`define VSRD_IMAX_MAX 4'h9
`define VSRD_DITH_LEVELS 4'h8
`define VSRD_DITH_STEP 10'h0cb
// Bit-rate codes in kbaud
`define VSRD_BAUD_20 9'h014
`define VSRD_BAUD_50 9'h032
`define VSRD_BAUD_125 9'h07d
`define VSRD_BAUD_250 9'h0fa
`define VSRD_BAUD_500 9'h1f4
// Time base: 0.1 s at 250 MHz, and dither half periods in cycles
`define VSRD_TENTH_CYCLES 32'd25000000
`define VSRD_DITH_HALF_0 32'd2000000
`define VSRD_DITH_HALF_1 32'd1506024
`define VSRD_DITH_HALF_2 32'd1000000
`endif

// *** verification/vsrd_checker_sva.sv ***
// Port checker for the valve setpoint block
`timescale 1ns/10ps
module vsrd_checker (
    input wire clk,
    input wire rst_n,
    input wire [5:0] addr,
    input wire [31:0] wdata,
    input wire wr_en,
    input wire rd_en,
    input wire [31:0] rdata,
    input wire [15:0] inv_freq,
    input wire [15:0] enc_freq,
    input wire [9:0] proportional_valve,
    input wire [6:0] pump_level,
    input wire [8:0] bus_rate_kbaud,
    input wire [3:0] pump_current_level,
    input wire [6:0] traction_ramp,
    input wire [6:0] pump_ramp
);
    // One clock domain, so clocking and reset are shared
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    ////////////////////////////////////////////////////////////////
    // Read data only in the cycle after a read strobe
    a_read_idle: assert property (!$past(rd_en) |-> rdata == 32'h0)
        else $error("read data outside read slot");
    a_valve_clamp: assert property (proportional_valve <= 10'h3e8)
        else $error("valve setpoint above full scale");
    a_pump_cap: assert property (pump_level <= 7'h64)
        else $error("pump level above 100");
    a_imax_range: assert property (pump_current_level <= 4'h9)
        else $error("pump current level above 9");
    a_ramp_range: assert property (traction_ramp <= 7'h64 && pump_ramp <= 7'h64)
        else $error("ramp time above 10 s");
    a_baud_codes: assert property (
        bus_rate_kbaud inside {9'h014, 9'h032, 9'h07d, 9'h0fa, 9'h1f4})
        else $error("illegal bit rate code");
    // Write effect must show within two cycles
    a_baud_follow: assert property (wr_en && addr == 6'h02 && wdata[24:16] == 9'h0fa
        |-> ##[1:2] bus_rate_kbaud == 9'h0fa)
        else $error("bit rate did not follow write");
    a_ramp_readback: assert property (wr_en && addr == 6'h01 ##2 rd_en && addr == 6'h01
        |=> rdata[15:0] == $past(wdata[15:0], 3))
        else $error("ramp times not kept");
    // Inputs steady long enough to pass the synchronisers
    a_slip_read: assert property (($stable(inv_freq) && $stable(enc_freq)) [*6]
        ##0 (rd_en && addr == 6'h0a) |=> rdata[15:0] == $past(inv_freq) - $past(enc_freq))
        else $error("slip reading wrong");
endmodule

// *** verification/vsrd_power_stage.sv ***
// Power stage model: coil and pump drive follow the commands
`timescale 1ns/10ps
module vsrd_power_stage (
    input wire clk,
    input wire rst_n,
    input wire [9:0] valve_cmd,
    input wire [6:0] pump_cmd,
    output reg [15:0] valve_edges,
    output reg [9:0] coil_current,
    output reg [6:0] pump_drive
);
    reg [9:0] last_cmd;
    // Coil settles one cycle late; every valve command change is counted for dither rate
    always @(posedge clk) begin
        if (!rst_n) begin
            valve_edges <= 16'h0000;
            coil_current <= 10'h000;
            pump_drive <= 7'h00;
            last_cmd <= 10'h000;
        end else begin
            last_cmd <= valve_cmd;
            coil_current <= valve_cmd;
            pump_drive <= pump_cmd;
            if (valve_cmd != last_cmd) valve_edges <= valve_edges + 16'h0001;
        end
    end
endmodule

// *** verification/tb_top.sv ***
// Testbench for the valve setpoint, ramp and dither block
`timescale 1ns/10ps
module tb_top;
    reg clk, rst_n, wr_en, rd_en;
    reg [5:0] addr;
    reg [31:0] wdata;
    wire [31:0] rdata;
    reg [9:0] pot_level, pump_current;
    reg raise_switch, lift_prop_active, steer_active, key_on;
    reg [15:0] inv_freq, enc_freq, inv_amplitude, batt_voltage;
    wire [9:0] proportional_valve, coil_current;
    wire [6:0] pump_level, traction_ramp, pump_ramp, pump_drive;
    wire [8:0] bus_rate_kbaud;
    wire [3:0] pump_current_level;
    wire [15:0] valve_edges;
    integer num_errors, compares, i;
    reg [9:0] vmax, vmin;
    reg [15:0] e0;
    reg [8:0] rate;
    ////////////////////////////////////////////////////////////////
    // Shortened time base keeps ramps to a few thousand cycles
    vsrd_valve_setpoint #(.TENTH_CYCLES(100), .DITH_HALF_0(4), .DITH_HALF_1(3),
        .DITH_HALF_2(2)) dut (.clk(clk), .rst_n(rst_n), .addr(addr), .wdata(wdata),
        .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata), .pot_level(pot_level),
        .raise_switch(raise_switch), .lift_prop_active(lift_prop_active),
        .steer_active(steer_active), .key_on(key_on), .pump_current(pump_current),
        .inv_freq(inv_freq), .enc_freq(enc_freq), .inv_amplitude(inv_amplitude),
        .batt_voltage(batt_voltage), .proportional_valve(proportional_valve),
        .pump_level(pump_level), .bus_rate_kbaud(bus_rate_kbaud),
        .pump_current_level(pump_current_level), .traction_ramp(traction_ramp),
        .pump_ramp(pump_ramp));
    vsrd_power_stage ps (.clk(clk), .rst_n(rst_n), .valve_cmd(proportional_valve),
        .pump_cmd(pump_level), .valve_edges(valve_edges), .coil_current(coil_current),
        .pump_drive(pump_drive));
    ////////////////////////////////////////////////////////////////
    // 250 MHz clock
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    task chk(input [31:0] seen, input [31:0] exp, input string nm);
        begin
            compares = compares + 1;
            if (seen !== exp) begin
                num_errors = num_errors + 1;
                $display("wrong value %0s exp %h seen %h", nm, exp, seen);
            end
        end
    endtask
    task wr(input [5:0] a, input [31:0] d);
        begin
            @(posedge clk);
            wr_en <= 1'b1;
            addr <= a;
            wdata <= d;
            @(posedge clk);
            wr_en <= 1'b0;
        end
    endtask
    // Read data stands only in the cycle after the strobe
    task rd(input [5:0] a, input [31:0] e, input string nm);
        begin
            @(posedge clk);
            rd_en <= 1'b1;
            addr <= a;
            @(posedge clk);
            rd_en <= 1'b0;
            #1 chk(rdata, e, nm);
        end
    endtask
    task waitc(input integer n);
        begin
            repeat (n) @(posedge clk);
            #1;
        end
    endtask
    // Coil extremes over a window, for dither amplitude
    task observe(input integer n);
        begin
            vmax = 10'h000;
            vmin = 10'h3ff;
            e0 = valve_edges;
            repeat (n) begin
                @(posedge clk);
                #1;
                if (coil_current > vmax) vmax = coil_current;
                if (coil_current < vmin) vmin = coil_current;
            end
        end
    endtask
    task wrap_up;
        begin
            $display("errors %0d compares %0d", num_errors, compares);
            if (num_errors == 0 && compares > 0)
                $display("TB: PASS");
            else
                $display("TB: FAIL");
            $finish;
        end
    endtask
    ////////////////////////////////////////////////////////////////
    task t_reset;
        begin
            rd(6'h00, 32'h03e80000, "valve");
            rd(6'h02, 32'h007d0000, "dither");
            rd(6'h04, 32'h00060000, "tract");
            rd(6'h05, 32'h000a0a0a, "smooth");
            rd(6'h06, 32'h00000303, "misc");
            rd(6'h3f, 32'h00000000, "unmapped");
            chk(bus_rate_kbaud, 32'h7d, "kbaud");
        end
    endtask
    // Out-of-range fields keep old values; boundaries are taken
    task t_limits;
        begin
            wr(6'h04, 32'h0a296465);
            rd(6'h04, 32'h00066400, "tract bad");
            wr(6'h04, 32'h09280a64);
            rd(6'h04, 32'h09280a64, "tract edge");
            chk({traction_ramp, pump_ramp, pump_current_level}, 32'h320a9, "outs");
            wr(6'h05, 32'h00333209);
            rd(6'h05, 32'h000a320a, "smooth");
            wr(6'h06, 32'h00001502);
            rd(6'h06, 32'h00000303, "misc bad");
            wr(6'h06, 32'h00001403);
            rd(6'h06, 32'h00001403, "misc edge");
            wr(6'h03, 32'h00000065);
            rd(6'h03, 32'h00000000, "pump bad");
            wr(6'h00, 32'h03e90000);
            rd(6'h00, 32'h03e80000, "ceil bad");
        end
    endtask
    task t_baud;
        begin
            for (i = 0; i < 6; i = i + 1) begin
                rate = (i == 0) ? 9'h014 : (i == 1) ? 9'h032 : (i == 2) ? 9'h07d :
                    (i == 3) ? 9'h0fa : (i == 4) ? 9'h1f4 : 9'h064;
                wr(6'h02, {7'h00, rate, 16'h0000});
                waitc(2);
                chk(bus_rate_kbaud, (i == 5) ? 9'h1f4 : rate, "kbaud");
            end
        end
    endtask
    // Rise 2.0 s is 2 cycles per permille here, fall 1.0 s is 1
    task t_ramp;
        begin
            wr(6'h01, 32'h00000a14);
            rd(6'h01, 32'h00000a14, "ramp");
            @(posedge clk) pot_level <= 10'h3ff;
            waitc(1000);
            chk(proportional_valve > 470 && proportional_valve < 530, 1, "rise");
            waitc(1100);
            chk(proportional_valve, 32'h3e8, "max");
            @(posedge clk) pot_level <= 10'h000;
            waitc(500);
            chk(proportional_valve > 470 && proportional_valve < 530, 1, "fall");
            waitc(600);
            chk(proportional_valve, 32'h0, "zero");
            wr(6'h00, 32'h03e800c8);
            waitc(500);
            chk(proportional_valve, 32'hc8, "floor");
            wr(6'h01, 32'h00000000);
            wr(6'h00, 32'h432000c8);
            waitc(6);
            chk(proportional_valve, 32'h0, "onoff off");
            wr(6'h00, 32'hc32000c8);
            waitc(6);
            chk(proportional_valve, 32'h320, "onoff on");
        end
    endtask
    // Level 8 is 20.3% of a 1000 ceiling; half periods 4, 3, 2 cycles
    task t_dither;
        begin
            wr(6'h00, 32'h03e801f4);
            for (i = 0; i < 3; i = i + 1) begin
                wr(6'h02, 32'h01f40008 | (i << 8));
                observe(120);
                chk({vmax, vmin}, {10'h2bf, 10'h129}, "dith amp");
                chk((valve_edges - e0) >= 120 / (4 - i) - 2 &&
                    (valve_edges - e0) <= 120 / (4 - i) + 2, 1, "dith rate");
            end
            wr(6'h02, 32'h01f40000);
            waitc(2);
            observe(40);
            chk({vmax, vmin}, {10'h1f4, 10'h1f4}, "dith off");
            wr(6'h00, 32'h03e80384);
            wr(6'h02, 32'h01f40008);
            observe(40);
            chk({vmax, vmin}, {10'h3e8, 10'h2b9}, "clamp");
        end
    endtask
    task t_pump;
        begin
            wr(6'h03, 32'h1400321e);
            @(posedge clk) raise_switch <= 1'b1;
            waitc(6);
            chk(pump_level, 32'h1e, "creep");
            @(posedge clk) lift_prop_active <= 1'b1;
            pump_current <= 10'h3ff;
            waitc(6);
            chk(pump_level == 49 || pump_level == 50, 1, "lift");
            @(posedge clk) steer_active <= 1'b1;
            wr(6'h03, 32'h1464321e);
            waitc(6);
            chk(pump_drive, 32'h64, "cap");
            @(posedge clk) pump_current <= 10'h200;
            waitc(6);
            chk(pump_level, 32'h46, "steer");
        end
    endtask
    task t_tester;
        begin
            @(posedge clk) inv_freq <= 16'h04b0;
            enc_freq <= 16'h03e8;
            inv_amplitude <= 16'h00f0;
            batt_voltage <= 16'h01e0;
            key_on <= 1'b1;
            waitc(8);
            rd(6'h0a, 32'h000000c8, "slip");
            rd(6'h0b, 32'h00000032, "motv");
            rd(6'h0c, 32'h000001e0, "batt");
            @(posedge clk) batt_voltage <= 16'h012c;
            waitc(8);
            rd(6'h0c, 32'h000001e0, "batt held");
            @(posedge clk) key_on <= 1'b0;
            waitc(6);
            @(posedge clk) key_on <= 1'b1;
            waitc(8);
            rd(6'h0c, 32'h0000012c, "batt key");
        end
    endtask
    ////////////////////////////////////////////////////////////////
    // Main sequence after a 16-cycle reset
    initial begin
        num_errors = 0;
        compares = 0;
        {rst_n, wr_en, rd_en, addr, wdata, pot_level, pump_current} = 0;
        {raise_switch, lift_prop_active, steer_active, key_on} = 4'h0;
        {inv_freq, enc_freq, inv_amplitude, batt_voltage} = 64'h0;
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        t_reset;
        t_limits;
        t_baud;
        t_ramp;
        t_dither;
        t_pump;
        t_tester;
        wrap_up;
    end
    // Watchdog well beyond the expected run
    initial begin
        #100000;
        num_errors = num_errors + 1;
        wrap_up;
    end
endmodule
bind vsrd_valve_setpoint vsrd_checker chk_i (.clk(clk), .rst_n(rst_n), .addr(addr),
    .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata), .inv_freq(inv_freq),
    .enc_freq(enc_freq), .proportional_valve(proportional_valve), .pump_level(pump_level),
    .bus_rate_kbaud(bus_rate_kbaud), .pump_current_level(pump_current_level),
    .traction_ramp(traction_ramp), .pump_ramp(pump_ramp));
